// File: hdl/dpcp_capture_top.sv
// DDR pixel capture port with AHB-Lite registers and serial configuration
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "dpcp_regs.svh"

// Summary of operation
// R01 - Ten-bit bus word feeds one channel
// R02 - Capture a word on both clock edges
// R03 - Marker flags final word of each group
// R04 - Three-colour or four-colour group packing
// R05 - Return-to-zero request blanks between pulses
// R06 - Low-power request forces outputs off
// R07 - Software sets I/O level field
// R08 - Pixel clock held low for PLL use; not done here, the pixel clock is only sampled for its edges
// R09 - Three-wire serial port, shared data line
// R10 - Stage words, release group together
module dpcp_capture_top #(
	parameter int DATA_W = 10,
	parameter int RTZ_ON_CYCLES = `DPCP_RTZ_ON_CYCLES
)
(
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic hready_in,
	input wire logic [31:0] hwdata_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire logic pixel_clk_in,
	input wire logic [DATA_W-1:0] pixel_bus_in,
	input wire logic pixel_sync_in,
	input wire logic return_zero_request_in,
	input wire logic low_power_request_in,
	input wire logic cfg_sclk_in,
	input wire logic cfg_sdio_in,
	output logic cfg_sdio_out,
	output logic cfg_sdio_oe_out,
	input wire logic cfg_serial_select_n_in,
	output logic [DATA_W-1:0] laser_ch0_out,
	output logic [DATA_W-1:0] laser_ch1_out,
	output logic [DATA_W-1:0] laser_ch2_out,
	output logic [DATA_W-1:0] laser_ch3_out,
	output logic group_strobe_out,
	output logic rtz_active_out,
	output logic low_power_out,
	output logic [1:0] io_level_out
);

	localparam int SW = DATA_W + 4;

	logic [SW-1:0] meta_reg;
	logic [SW-1:0] sync_reg;
	logic pclk_last_reg;
	logic [DATA_W-1:0] pix_data;
	logic pclk_s, psync_s, rtz_s, lpwr_s, pclk_edge;

	logic wr_pend_reg, wr_pend_next;
	logic [7:0] wr_addr_reg, wr_addr_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic hreadyout_reg, hreadyout_next;
	logic take;

	logic [1:0] ctrl_reg, ctrl_next;
	logic [1:0] io_level_reg, io_level_next;
	logic ovr_reg, ovr_next;
	logic ser_wr;
	logic [6:0] ser_addr;
	logic [7:0] ser_data;
	logic [31:0] ser_rd_word;

	logic [DATA_W-1:0] stage_reg [4], stage_next [4];
	logic [DATA_W-1:0] group_reg [4], group_next [4];
	logic [1:0] idx_reg, idx_next;
	logic strobe_reg, strobe_next;
	logic [15:0] gcnt_reg, gcnt_next;
	logic ovr_set;
	dpcp_pkg::dpcp_mode_t mode;
	logic cap_en;
	logic [1:0] last;

	logic [DATA_W-1:0] drive_reg [4], drive_next [4];
	logic [7:0] rtz_cnt_reg, rtz_cnt_next;
	logic rtz_act_reg, lpwr_act_reg;
	logic blank;

	// Index of the final word of a group in the given packing
	function automatic logic [1:0] last_index(input dpcp_pkg::dpcp_mode_t m);
		return (m == dpcp_pkg::DPCP_MODE_FOUR) ? `DPCP_LAST_IDX_FOUR : `DPCP_LAST_IDX_THREE;
	endfunction

	// Shared read decode for AHB and serial; unmapped offsets read zero
	function automatic logic [31:0] reg_read(input logic [7:0] ofs);
		logic [31:0] v;
		v = 32'h0;
		unique case (ofs)
			`DPCP_CTRL_OFS: v = {30'h0, ctrl_reg};
			`DPCP_STATUS_OFS: v = {gcnt_reg, 10'h000, idx_reg, 1'h0, ovr_reg, lpwr_act_reg,
				rtz_act_reg};
			`DPCP_IO_LEVEL_OFS: v = {24'h0, io_level_reg, 6'h00};
			`DPCP_CH0_OFS: v = 32'(group_reg[0]);
			`DPCP_CH1_OFS: v = 32'(group_reg[1]);
			`DPCP_CH2_OFS: v = 32'(group_reg[2]);
			`DPCP_CH3_OFS: v = 32'(group_reg[3]);
			default: v = 32'h0;
		endcase
		return v;
	endfunction

	default clocking dflt_cb @(posedge mclk_in); endclocking
	default disable iff (!nrst_in);

	////////////////////////////////////////////////////////////////////////////////
	// Link pins: pixel clock is sampled like data and its edges found here
	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
			pclk_last_reg <= 1'h0;
		end
		else
		begin
			meta_reg <= {low_power_request_in, return_zero_request_in, pixel_sync_in,
				pixel_clk_in, pixel_bus_in};
			sync_reg <= meta_reg;
			pclk_last_reg <= sync_reg[DATA_W];
		end
	end

	assign pix_data = sync_reg[DATA_W-1:0];
	assign pclk_s = sync_reg[DATA_W];
	assign psync_s = sync_reg[DATA_W+1];
	assign rtz_s = sync_reg[DATA_W+2];
	assign lpwr_s = sync_reg[DATA_W+3];
	assign pclk_edge = pclk_s ^ pclk_last_reg; // R02

	////////////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: zero-wait reads, one wait state on writes so a
	// following read always sees the written value
	assign take = hsel_in && htrans_in[1] && hready_in;

	always_comb
	begin
		wr_pend_next = take && hwrite_in;
		wr_addr_next = take ? haddr_in[7:0] : wr_addr_reg;
		hrdata_next = (take && !hwrite_in) ? reg_read(haddr_in[7:0]) : hrdata_reg;
		hreadyout_next = !(take && hwrite_in);
	end

	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			wr_pend_reg <= 1'h0;
			wr_addr_reg <= 8'h00;
			hrdata_reg <= 32'h0;
			hreadyout_reg <= 1'h1;
		end
		else
		begin
			wr_pend_reg <= wr_pend_next;
			wr_addr_reg <= wr_addr_next;
			hrdata_reg <= hrdata_next;
			hreadyout_reg <= hreadyout_next;
		end
	end

	assign hrdata_out = hrdata_reg;
	assign hreadyout_out = hreadyout_reg;
	assign hresp_out = 1'h0;

	////////////////////////////////////////////////////////////////////////////////
	// Configuration registers; AHB wins over a serial write in the same cycle
	always_comb
	begin
		ctrl_next = ctrl_reg;
		io_level_next = io_level_reg;
		if (wr_pend_reg && wr_addr_reg == `DPCP_CTRL_OFS)
			ctrl_next = hwdata_in[`DPCP_CTRL_MSB:0];
		else if (ser_wr && {1'h0, ser_addr} == `DPCP_CTRL_OFS)
			ctrl_next = ser_data[`DPCP_CTRL_MSB:0];
		if (wr_pend_reg && wr_addr_reg == `DPCP_IO_LEVEL_OFS)
			io_level_next = hwdata_in[`DPCP_IO_LEVEL_MSB:`DPCP_IO_LEVEL_LSB]; // R07
		else if (ser_wr && {1'h0, ser_addr} == `DPCP_IO_LEVEL_OFS)
			io_level_next = ser_data[`DPCP_IO_LEVEL_MSB:`DPCP_IO_LEVEL_LSB]; // R07
		// New error beats a simultaneous write-one-to-clear
		if (ovr_set)
			ovr_next = 1'h1;
		else if (wr_pend_reg && wr_addr_reg == `DPCP_STATUS_OFS && hwdata_in[`DPCP_STAT_OVR_BIT])
			ovr_next = 1'h0;
		else
			ovr_next = ovr_reg;
	end

	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			ctrl_reg <= `DPCP_CTRL_RESET;
			io_level_reg <= `DPCP_IO_LEVEL_RESET;
			ovr_reg <= 1'h0;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			io_level_reg <= io_level_next;
			ovr_reg <= ovr_next;
		end
	end

	assign io_level_out = io_level_reg;
	// Process, not assign: the function reads registers beyond its argument
	always_comb
		ser_rd_word = reg_read({1'h0, ser_addr});

	dpcp_serial_cfg u_serial
	(
		.mclk_in(mclk_in),
		.nrst_in(nrst_in),
		.sclk_in(cfg_sclk_in),
		.sdio_in(cfg_sdio_in),
		.select_n_in(cfg_serial_select_n_in),
		.rd_data_in(ser_rd_word[7:0]),
		.sdio_out(cfg_sdio_out),
		.sdio_oe_out(cfg_sdio_oe_out),
		.wr_strobe_out(ser_wr),
		.addr_out(ser_addr),
		.wr_data_out(ser_data)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Word capture and group assembly
	assign mode = dpcp_pkg::dpcp_mode_t'(ctrl_reg[`DPCP_CTRL_MODE_BIT]);
	assign cap_en = ctrl_reg[`DPCP_CTRL_EN_BIT];
	assign last = last_index(mode); // R04

	always_comb
	begin
		stage_next = stage_reg;
		group_next = group_reg;
		idx_next = idx_reg;
		strobe_next = 1'h0;
		gcnt_next = gcnt_reg;
		ovr_set = 1'h0;
		if (!cap_en)
			idx_next = 2'h0;
		else if (pclk_edge)
		begin
			if (idx_reg <= last)
				stage_next[idx_reg] = pix_data; // R01 R02
			if (psync_s)
			begin
				// Unused fourth channel stays dark in three-colour packing
				for (int ch = 0; ch < 4; ch++)
					group_next[ch] = (2'(ch) <= last) ? stage_next[ch] : '0; // R04 R10
				idx_next = 2'h0; // R03
				strobe_next = 1'h1; // R03
				gcnt_next = gcnt_reg + 16'h1;
				ovr_set = (idx_reg != last);
			end
			else if (idx_reg >= last)
				ovr_set = 1'h1; // Missing marker: last slot is overwritten
			else
				idx_next = idx_reg + 2'h1;
		end
	end

	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			stage_reg <= '{default: '0};
			group_reg <= '{default: '0};
			idx_reg <= 2'h0;
			strobe_reg <= 1'h0;
			gcnt_reg <= 16'h0;
		end
		else
		begin
			stage_reg <= stage_next;
			group_reg <= group_next;
			idx_reg <= idx_next;
			strobe_reg <= strobe_next;
			gcnt_reg <= gcnt_next;
		end
	end

	assign group_strobe_out = strobe_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Output drive: each group is pulsed for a fixed time under return-to-zero
	assign blank = lpwr_s || (rtz_s && rtz_cnt_reg == 8'h00); // R05 R06

	always_comb
	begin
		if (strobe_next)
			rtz_cnt_next = 8'(RTZ_ON_CYCLES);
		else if (rtz_cnt_reg != 8'h00)
			rtz_cnt_next = rtz_cnt_reg - 8'h1;
		else
			rtz_cnt_next = rtz_cnt_reg;
		for (int ch = 0; ch < 4; ch++)
			drive_next[ch] = blank ? '0 : group_reg[ch]; // R05 R06
	end

	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			drive_reg <= '{default: '0};
			rtz_cnt_reg <= 8'h00;
			rtz_act_reg <= 1'h0;
			lpwr_act_reg <= 1'h0;
		end
		else
		begin
			drive_reg <= drive_next;
			rtz_cnt_reg <= rtz_cnt_next;
			rtz_act_reg <= rtz_s;
			lpwr_act_reg <= lpwr_s;
		end
	end

	assign laser_ch0_out = drive_reg[0];
	assign laser_ch1_out = drive_reg[1];
	assign laser_ch2_out = drive_reg[2];
	assign laser_ch3_out = drive_reg[3];
	assign rtz_active_out = rtz_act_reg;
	assign low_power_out = lpwr_act_reg;

	////////////////////////////////////////////////////////////////////////////////
	a_first_word: assert property (pclk_edge && cap_en && idx_reg == 2'h0 && !psync_s // R01
		|=> stage_reg[0] == $past(pix_data))
		else $error("first word of a group not staged");
	a_fall_capture: assert property (!pclk_s && pclk_last_reg && cap_en && idx_reg == 2'h1 // R02
		&& !psync_s |=> stage_reg[1] == $past(pix_data) && idx_reg == 2'h2)
		else $error("word on falling pixel edge not captured");
	a_marker_group: assert property (pclk_edge && cap_en && psync_s // R03
		|=> group_strobe_out && idx_reg == 2'h0 ##1 !group_strobe_out)
		else $error("marked word did not close the group");
	a_four_last: assert property (pclk_edge && cap_en && psync_s && idx_reg == 2'h3 // R04
		&& mode == dpcp_pkg::DPCP_MODE_FOUR |=> group_reg[3] == $past(pix_data))
		else $error("fourth colour not released in four-colour packing");
	a_three_dark: assert property (group_strobe_out && mode == dpcp_pkg::DPCP_MODE_THREE // R04
		|-> group_reg[3] == '0)
		else $error("fourth channel loaded in three-colour packing");
	a_group_hold: assert property (!pclk_edge |=> group_reg[0] == $past(group_reg[0]) // R10
		&& group_reg[2] == $past(group_reg[2]))
		else $error("output group changed without a marked word");
	a_rtz_pulse: assert property (group_strobe_out && rtz_s && !lpwr_s // R05
		##0 (rtz_s && !lpwr_s && !pclk_edge) [*4] |=> laser_ch0_out == '0)
		else $error("return-to-zero pulse did not end");
	a_lpwr_off: assert property (lpwr_s |=> laser_ch0_out == '0 && laser_ch3_out == '0 // R06
		&& low_power_out)
		else $error("outputs active in low power");
	a_pass_through: assert property (!lpwr_s && !rtz_s // R06
		|=> laser_ch1_out == $past(group_reg[1]))
		else $error("channel not driven from its group value");
	a_io_level: assert property (wr_pend_reg && wr_addr_reg == `DPCP_IO_LEVEL_OFS // R07
		|=> io_level_out == $past(hwdata_in[`DPCP_IO_LEVEL_MSB:`DPCP_IO_LEVEL_LSB]))
		else $error("I/O level field not written");
	a_ovr_set_wins: assert property (ovr_set |=> ovr_reg) // R03
		else $error("group error flag lost");

	c_group_three: cover property (group_strobe_out && mode == dpcp_pkg::DPCP_MODE_THREE);
	c_group_four: cover property (group_strobe_out && mode == dpcp_pkg::DPCP_MODE_FOUR);
	c_overrun: cover property ($rose(ovr_reg));
	c_rtz_blank: cover property (rtz_s && group_strobe_out ##[1:20] laser_ch0_out == '0);

endmodule

// File: include/dpcp_regs.svh
// Register map, field positions, reset values and timing constants of the pixel capture port
`ifndef DPCP_REGS_SVH
`define DPCP_REGS_SVH

`define DPCP_CTRL_OFS 8'h00
`define DPCP_STATUS_OFS 8'h04
`define DPCP_IO_LEVEL_OFS 8'h08
`define DPCP_CH0_OFS 8'h0C
`define DPCP_CH1_OFS 8'h10
`define DPCP_CH2_OFS 8'h14
`define DPCP_CH3_OFS 8'h18

`define DPCP_CTRL_MODE_BIT 0
`define DPCP_CTRL_EN_BIT 1
`define DPCP_CTRL_MSB 1
`define DPCP_CTRL_RESET 2'h2
`define DPCP_STAT_OVR_BIT 2
`define DPCP_IO_LEVEL_MSB 7
`define DPCP_IO_LEVEL_LSB 6
`define DPCP_IO_LEVEL_RESET 2'h0

`define DPCP_LAST_IDX_THREE 2'h2
`define DPCP_LAST_IDX_FOUR 2'h3
`define DPCP_SER_BITS 4'h8

`define DPCP_CLK_PERIOD_NS 10
`define DPCP_RTZ_ON_NS 30
`define DPCP_RTZ_ON_CYCLES ((`DPCP_RTZ_ON_NS + `DPCP_CLK_PERIOD_NS - 1) / `DPCP_CLK_PERIOD_NS)

`endif

// File: include/dpcp_pkg.sv
// Types shared by the pixel capture port modules
package dpcp_pkg;

	typedef enum logic [1:0]
	{
		DPCP_SER_IDLE = 2'h0,
		DPCP_SER_ADDR = 2'h1,
		DPCP_SER_DATA = 2'h3,
		DPCP_SER_DONE = 2'h2
	} dpcp_ser_state_t;

	typedef enum logic
	{
		DPCP_MODE_THREE = 1'h0,
		DPCP_MODE_FOUR = 1'h1
	} dpcp_mode_t;

endpackage

// File: hdl/dpcp_serial_cfg.sv
// Three-wire serial configuration slave with a shared data line
`timescale 1ns/1ps
`include "dpcp_regs.svh"

module dpcp_serial_cfg
(
	input wire logic mclk_in,
	input wire logic nrst_in,
	input wire logic sclk_in,
	input wire logic sdio_in,
	input wire logic select_n_in,
	input wire logic [7:0] rd_data_in,
	output logic sdio_out,
	output logic sdio_oe_out,
	output logic wr_strobe_out,
	output logic [6:0] addr_out,
	output logic [7:0] wr_data_out
);

	logic [2:0] meta_reg;
	logic [2:0] sync_reg;
	logic sclk_last_reg;
	dpcp_pkg::dpcp_ser_state_t state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] sh_reg, sh_next;
	logic read_reg, read_next;
	logic loaded_reg, loaded_next;
	logic [6:0] addr_reg, addr_next;
	logic oe_reg, oe_next;
	logic out_reg, out_next;
	logic strobe_reg, strobe_next;
	logic [7:0] wdata_reg, wdata_next;
	logic sclk_s, sdio_s, sel_n_s, rise, fall;

	////////////////////////////////////////////////////////////////////////////////
	// Pins cross two flops; only the second stage is looked at
	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			// Serial clock idles low: no false edge after reset
			meta_reg <= 3'h6;
			sync_reg <= 3'h6;
			sclk_last_reg <= 1'h0;
		end
		else
		begin
			meta_reg <= {select_n_in, sdio_in, sclk_in};
			sync_reg <= meta_reg;
			sclk_last_reg <= sync_reg[0];
		end
	end

	assign sclk_s = sync_reg[0];
	assign sdio_s = sync_reg[1];
	assign sel_n_s = sync_reg[2];
	assign rise = sclk_s && !sclk_last_reg;
	assign fall = !sclk_s && sclk_last_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Frame: read flag, 7 address bits, 8 data bits, MSB first, sampled on rise
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		read_next = read_reg;
		loaded_next = loaded_reg;
		addr_next = addr_reg;
		oe_next = oe_reg;
		out_next = out_reg;
		strobe_next = 1'h0;
		wdata_next = wdata_reg;
		if (sel_n_s)
		begin
			state_next = dpcp_pkg::DPCP_SER_IDLE;
			cnt_next = 4'h0;
			oe_next = 1'h0; // R09
			loaded_next = 1'h0;
		end
		else
		begin
			unique case (state_reg)
				dpcp_pkg::DPCP_SER_IDLE, dpcp_pkg::DPCP_SER_ADDR:
				begin
					state_next = dpcp_pkg::DPCP_SER_ADDR;
					if (rise)
					begin
						sh_next = {sh_reg[6:0], sdio_s};
						cnt_next = cnt_reg + 4'h1;
						if (cnt_reg == `DPCP_SER_BITS - 4'h1)
						begin
							state_next = dpcp_pkg::DPCP_SER_DATA;
							cnt_next = 4'h0;
							read_next = sh_next[7];
							addr_next = sh_next[6:0];
						end
					end
				end
				dpcp_pkg::DPCP_SER_DATA:
				begin
					if (read_reg && !loaded_reg)
					begin
						// Address settles one cycle before the read value is taken
						sh_next = rd_data_in;
						out_next = rd_data_in[7];
						oe_next = 1'h1; // R09
						loaded_next = 1'h1;
					end
					else if (read_reg && fall && cnt_reg != 4'h0)
					begin
						sh_next = {sh_reg[6:0], 1'h0};
						out_next = sh_reg[6];
					end
					else if (rise)
					begin
						cnt_next = cnt_reg + 4'h1;
						if (!read_reg)
							sh_next = {sh_reg[6:0], sdio_s};
						if (cnt_reg == `DPCP_SER_BITS - 4'h1)
						begin
							state_next = dpcp_pkg::DPCP_SER_DONE;
							oe_next = 1'h0;
							strobe_next = !read_reg;
							wdata_next = {sh_reg[6:0], sdio_s};
						end
					end
				end
				dpcp_pkg::DPCP_SER_DONE:
					oe_next = 1'h0;
			endcase
		end
	end

	always_ff @(posedge mclk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			state_reg <= dpcp_pkg::DPCP_SER_IDLE;
			cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			read_reg <= 1'h0;
			loaded_reg <= 1'h0;
			addr_reg <= 7'h00;
			oe_reg <= 1'h0;
			out_reg <= 1'h0;
			strobe_reg <= 1'h0;
			wdata_reg <= 8'h00;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			read_reg <= read_next;
			loaded_reg <= loaded_next;
			addr_reg <= addr_next;
			oe_reg <= oe_next;
			out_reg <= out_next;
			strobe_reg <= strobe_next;
			wdata_reg <= wdata_next;
		end
	end

	assign sdio_out = out_reg;
	assign sdio_oe_out = oe_reg;
	assign wr_strobe_out = strobe_reg;
	assign addr_out = addr_reg;
	assign wr_data_out = wdata_reg;

	////////////////////////////////////////////////////////////////////////////////
	a_sdio_release: assert property (@(posedge mclk_in) disable iff (!nrst_in) // R09
		sel_n_s |=> !sdio_oe_out)
		else $error("data line driven while deselected");
	a_write_done: assert property (@(posedge mclk_in) disable iff (!nrst_in) // R09
		wr_strobe_out |-> state_reg == dpcp_pkg::DPCP_SER_DONE && !read_reg)
		else $error("serial write strobe outside a finished write frame");
	c_serial_read: cover property (@(posedge mclk_in) disable iff (!nrst_in)
		sdio_oe_out ##1 !sdio_oe_out);

endmodule

// File: verification/dpcp_pixel_source.sv
// Video controller model driving DDR pixel words and the group marker
`timescale 1ns/1ps

module dpcp_pixel_source
(
	output logic pixel_clk_out,
	output logic [9:0] pixel_bus_out,
	output logic pixel_sync_out
);
	initial
	begin
		pixel_clk_out = 1'b0;
		pixel_bus_out = 10'h155;
		pixel_sync_out = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One word per clock edge; the clock parks between groups
	task automatic send_group(input logic [39:0] w, input int n, input int mark);
		// Start off the sampling edge of the system clock
		#2;
		for (int k = 0; k < n; k++)
		begin
			pixel_bus_out = w[k*10 +: 10];
			pixel_sync_out = (k == mark);
			#31.25;
			pixel_clk_out = ~pixel_clk_out;
			#31.25;
		end
		// Hold time over: inverse so a late sample cannot match
		pixel_bus_out = ~pixel_bus_out;
		pixel_sync_out = 1'b0;
	endtask
endmodule

// File: verification/ddr_pixel_capture_port_test.sv
// Self-checking bench for the DDR pixel capture port
`timescale 1ns/1ps

module ddr_pixel_capture_port_test;
	localparam int RTZ_N = 3;
	logic mclk_in, nrst_in, hsel, hwrite, ready, hresp, pclk, psync, return_zero_request, lpreq;
	logic sclk, sdio_pin, sdio_drv, sdio_out, sdio_oe, sel_n, strobe, rtz_act, lp_act;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans, io_lvl;
	logic [9:0] pbus;
	logic [9:0] ch [4];
	int n_errors = 0;
	int samples_checked = 0;

	// Open line: device wins while enabled, else bench level
	assign sdio_pin = sdio_oe ? sdio_out : sdio_drv;

	dpcp_capture_top #(.DATA_W(10), .RTZ_ON_CYCLES(RTZ_N)) dut_u
	(
		.mclk_in(mclk_in), .nrst_in(nrst_in), .hsel_in(hsel), .haddr_in(haddr),
		.htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(ready),
		.hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(ready), .hresp_out(hresp),
		.pixel_clk_in(pclk), .pixel_bus_in(pbus), .pixel_sync_in(psync),
		.return_zero_request_in(return_zero_request), .low_power_request_in(lpreq),
		.cfg_sclk_in(sclk), .cfg_sdio_in(sdio_pin), .cfg_sdio_out(sdio_out),
		.cfg_sdio_oe_out(sdio_oe), .cfg_serial_select_n_in(sel_n),
		.laser_ch0_out(ch[0]), .laser_ch1_out(ch[1]), .laser_ch2_out(ch[2]),
		.laser_ch3_out(ch[3]), .group_strobe_out(strobe), .rtz_active_out(rtz_act),
		.low_power_out(lp_act), .io_level_out(io_lvl)
	);

	dpcp_pixel_source src_u
	(
		.pixel_clk_out(pclk),
		.pixel_bus_out(pbus),
		.pixel_sync_out(psync)
	);

	initial
	begin
		mclk_in = 1'b0;
		forever #5 mclk_in = ~mclk_in;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic summarize();
		$display("checked %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_ch(input logic [39:0] e);
		for (int k = 0; k < 4; k++)
			check({22'h000000, ch[k]}, {22'h000000, e[k*10 +: 10]});
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge mclk_in);
		#1;
	endtask

	task automatic wait_ready();
		int i;
		i = 0;
		do
		begin
			@(posedge mclk_in);
			i++;
		end
		while (ready !== 1'b1 && i < 50);
		if (ready !== 1'b1)
		begin
			n_errors++;
			summarize();
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge mclk_in);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h000000, a};
		hwrite <= wr;
		wait_ready();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_ready();
		r = hrdata;
	endtask

	// Send a group and stop at the edge that sees the strobe
	task automatic group(input logic [39:0] w, input int n, input int mark);
		int i;
		logic [9:0] old;
		i = 0;
		old = ch[0];
		fork
			src_u.send_group(w, n, mark);
		join_none
		do
		begin
			@(posedge mclk_in);
			i++;
		end
		while (strobe !== 1'b1 && i < 200);
		if (strobe !== 1'b1)
		begin
			n_errors++;
			summarize();
		end
		check({22'h000000, ch[0]}, {22'h000000, old});
		#1;
		check({31'h00000000, strobe}, 32'h0);
	endtask

	// Sclk idles low; a released line toggles so no stale level survives
	task automatic ser_frame(input logic [15:0] f, output logic [7:0] got);
		#3;
		sel_n = 1'b0;
		#100;
		for (int i = 15; i >= 0; i--)
		begin
			sdio_drv = (f[15] && i < 8) ? ~sdio_drv : f[i];
			#62.5;
			sclk = 1'b1;
			if (i < 8)
				got[i] = sdio_pin;
			#62.5;
			sclk = 1'b0;
		end
		#100;
		sel_n = 1'b1;
		sdio_drv = ~sdio_drv;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		check({30'h0, io_lvl}, 32'h0);
		ahb(1'b0, 8'h1C, 32'h0);
		check(r, 32'h0);
		check({31'h0, hresp}, 32'h0);
		for (int k = 3; k >= 0; k--)
		begin
			ahb(1'b1, 8'h08, 32'hFFFFFF3F | (32'(k) << 6));
			ahb(1'b0, 8'h08, 32'h0);
			check(r, 32'(k) << 6);
			check({30'h0, io_lvl}, 32'(k));
		end
	endtask

	task automatic t_three();
		ahb(1'b0, 8'h00, 32'h0);
		check(r, 32'h2);
		group({10'h000, 10'h3FF, 10'h201, 10'h155}, 3, 2);
		check_ch({10'h000, 10'h3FF, 10'h201, 10'h155});
		ahb(1'b0, 8'h0C, 32'h0);
		check(r, 32'h155);
		ahb(1'b0, 8'h14, 32'h0);
		check(r, 32'h3FF);
	endtask

	task automatic t_four();
		ahb(1'b1, 8'h00, 32'h3);
		group({10'h001, 10'h30C, 10'h0F0, 10'h2AA}, 4, 3);
		check_ch({10'h001, 10'h30C, 10'h0F0, 10'h2AA});
		ahb(1'b0, 8'h04, 32'h0);
		check({16'h0, r[31:16]}, 32'h2);
	endtask

	task automatic t_lpwr();
		@(posedge mclk_in);
		lpreq <= 1'b1;
		tick(6);
		check({31'h0, lp_act}, 32'h1);
		check_ch(40'h0);
		@(posedge mclk_in);
		lpreq <= 1'b0;
		tick(6);
		check_ch({10'h001, 10'h30C, 10'h0F0, 10'h2AA});
	endtask

	task automatic t_err();
		group({20'h0, 10'h0AB, 10'h0CD}, 2, 1);
		ahb(1'b0, 8'h04, 32'h0);
		check({31'h0, r[2]}, 32'h1);
		ahb(1'b1, 8'h04, 32'h4);
		ahb(1'b0, 8'h04, 32'h0);
		check({31'h0, r[2]}, 32'h0);
	endtask

	// Words sent with capture disabled must leave group and count alone
	task automatic t_off();
		ahb(1'b1, 8'h00, 32'h1);
		src_u.send_group({10'h3FF, 10'h3FF, 10'h3FF, 10'h3FF}, 4, 3);
		tick(8);
		check_ch({10'h001, 10'h30C, 10'h0AB, 10'h0CD});
		ahb(1'b0, 8'h04, 32'h0);
		check({16'h0, r[31:16]}, 32'h3);
		ahb(1'b1, 8'h00, 32'h3);
	endtask

	task automatic t_rtz();
		@(posedge mclk_in);
		return_zero_request <= 1'b1;
		tick(8);
		check({31'h0, rtz_act}, 32'h1);
		group({10'h111, 10'h222, 10'h333, 10'h3C3}, 4, 3);
		check_ch({10'h111, 10'h222, 10'h333, 10'h3C3});
		tick(RTZ_N - 1);
		check({22'h0, ch[0]}, 32'h3C3);
		tick(1);
		check_ch(40'h0);
		@(posedge mclk_in);
		return_zero_request <= 1'b0;
	endtask

	task automatic t_serial();
		logic [7:0] got;
		ser_frame({1'b0, 7'h08, 8'h80}, got);
		tick(10);
		check({30'h0, io_lvl}, 32'h2);
		ser_frame({1'b1, 7'h08, 8'h00}, got);
		check({24'h0, got}, 32'h80);
		tick(4);
		check({31'h0, sdio_oe}, 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		nrst_in = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		return_zero_request = 1'b0;
		lpreq = 1'b0;
		sclk = 1'b0;
		sdio_drv = 1'b0;
		sel_n = 1'b1;
		repeat (12) @(posedge mclk_in);
		nrst_in <= 1'b1;
		t_regs();
		t_three();
		t_four();
		t_lpwr();
		t_err();
		t_off();
		t_rtz();
		t_serial();
		summarize();
	end
endmodule
